// *** hw/tmas_consts.svh ***
// constants for the temperature monitor alert and standby block
`ifndef TMAS_CONSTS_SVH
`define TMAS_CONSTS_SVH

// smbus addresses
`define TMAS_ARA           7'h0C
`define TMAS_DEV_ADDR_BASE 7'h4C

// register pointers, read side
`define TMAS_REG_LOC_VAL   8'h00
`define TMAS_REG_REM_VAL   8'h01
`define TMAS_REG_STATUS    8'h02
`define TMAS_REG_CFG_RD    8'h03
`define TMAS_REG_LHI_RD    8'h05
`define TMAS_REG_LLO_RD    8'h06
`define TMAS_REG_RHI_RD    8'h07
`define TMAS_REG_RLO_RD    8'h08
// register pointers, write side
`define TMAS_REG_CFG_WR    8'h09
`define TMAS_REG_LHI_WR    8'h0B
`define TMAS_REG_LLO_WR    8'h0C
`define TMAS_REG_RHI_WR    8'h0D
`define TMAS_REG_RLO_WR    8'h0E
`define TMAS_REG_ONE_SHOT  8'h0F
`define TMAS_RD_UNMAPPED   8'h00

// configuration and status fields
`define TMAS_CFG_STBY_BIT  6
`define TMAS_CFG_RST       8'h00
// flag vector index; status byte is {0, flags[4:0], 00}, so open sits at bit 2
`define TMAS_FL_OPEN       0
`define TMAS_FL_RLO        1
`define TMAS_FL_RHI        2
`define TMAS_FL_LLO        3
`define TMAS_FL_LHI        4

// limit array index and power-on values (-55 for the lows)
`define TMAS_LIM_LHI       0
`define TMAS_LIM_LLO       1
`define TMAS_LIM_RHI       2
`define TMAS_LIM_RLO       3
`define TMAS_LIM_HI_RST    8'h7F
`define TMAS_LIM_LO_RST    8'hC9
`define TMAS_UNDER_RANGE   8'h80

// timing
`define TMAS_CLK_MHZ       250
`define TMAS_CONV_TIME_US  100
`define TMAS_CONV_PER_US   1000
`define TMAS_STRAP_WAIT    2'h2

`endif

// *** hw/tmas_pkg.sv ***
// types for the temperature monitor alert and standby block
package tmas_pkg;

  typedef enum logic [1:0] {
    TMAS_EV_START = 2'h0,
    TMAS_EV_STOP  = 2'h1,
    TMAS_EV_RISE  = 2'h2,
    TMAS_EV_FALL  = 2'h3
  } tmas_ev_t;

  typedef enum logic [2:0] {
    TMAS_SMB_IDLE  = 3'h0,
    TMAS_SMB_ADDR  = 3'h1,
    TMAS_SMB_ACK   = 3'h3,
    TMAS_SMB_WDATA = 3'h2,
    TMAS_SMB_RDATA = 3'h6,
    TMAS_SMB_RACK  = 3'h7
  } tmas_smb_t;

  typedef enum logic {
    TMAS_CV_IDLE = 1'h0,
    TMAS_CV_RUN  = 1'h1
  } tmas_conv_t;

  // link-clock side state
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [2:0] scl;
    logic [2:0] sda;
    logic       tog;
    tmas_ev_t   kind;
    logic       ev_sda;
  } tmas_link_t;

  // converter result from the analog front end
  typedef struct packed {
    logic [7:0] local_temp;
    logic [7:0] remote_temp;
    logic       remote_low;
  } tmas_adc_t;

  // core-clock side state
  typedef struct packed {
    logic [2:0]      tog_sync;
    logic [1:0]      open_sync;
    logic [1:0][1:0] strap_sync;
    logic [1:0]      strap_cnt;
    logic [6:0]      dev_addr;
    tmas_smb_t       smb;
    logic [3:0]      bit_cnt;
    logic [7:0]      shreg;
    logic [7:0]      txbyte;
    logic            rw;
    logic            ara;
    logic            first;
    logic            more;
    logic            sda_oe;
    logic [7:0]      cfg;
    logic [7:0]      ptr;
    logic [3:0][7:0] lim;
    logic [7:0]      loc_val;
    logic [7:0]      rem_val;
    tmas_conv_t      conv;
    logic            oneshot;
    logic [19:0]     cnt;
    logic [19:0]     period_cnt;
    logic [4:0]      cond;
    logic [4:0]      flags;
    logic            alert;
    logic            conv_start;
  } tmas_core_t;

endpackage

// *** hw/tmas_top.sv ***
// alert, standby and sensor-fault logic with its smbus slave
`timescale 1ns/1ps
`include "tmas_consts.svh"

// Function
// (RULE_01) Alert pin pulls low when a finished reading is outside its limits.
// (RULE_02) Alert pin also pulls low when the remote diode is open.
// (RULE_03) Alert pin is open drain: only pulls low, never drives high.
// (RULE_04) Master answers a low alert with a read to address 0001100.
// (RULE_05) No device uses the alert response address as its own.
// (RULE_06) While alerting, acknowledge that read and return our own address.
// (RULE_07) Several responders arbitrate on data; a lost bit makes us withdraw.
// (RULE_08) After a won response, release alert only if the cause has gone.
// (RULE_09) Master repeats alert response reads while the line stays low.
// (RULE_10) Configuration bit 6 set inhibits the converter; clear runs normally.
// (RULE_11) Entering standby aborts a running conversion and discards its result.
// (RULE_12) The serial slave keeps full register access during standby.
// (RULE_13) In standby a write to 0Fh starts one conversion of both channels.
// (RULE_14) One-shot also compares limits, then returns to standby; data is ignored.
// (RULE_15) Remote open comparator is sampled at conversion start into status bit 2.
// (RULE_16) Remote input below range reads as 80h (-128).
// (RULE_17) A -128 remote reading trips the default low limit normally.
// (RULE_18) Software may silence a shorted unused channel by low limit 80h.
// (RULE_19) High compare is strictly greater, low compare strictly less.
// (RULE_20) Alert is the OR of held limit and open flags, released by response.
module tmas_top #(
  parameter int unsigned CONV_CYCLES   = `TMAS_CONV_TIME_US * `TMAS_CLK_MHZ,
  parameter int unsigned PERIOD_CYCLES = `TMAS_CONV_PER_US * `TMAS_CLK_MHZ
) (
  // core clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  // smbus pins; inputs sampled on the link clock, outputs from the core clock
  input  wire logic             i_link_clk,
  input  wire logic             i_scl,
  input  wire logic             i_sda,
  output logic                  o_sda_out,
  output logic                  o_sda_oe,
  // alert pin, open drain
  output logic                  o_alert_n_out,
  output logic                  o_alert_n_oe,
  // address strap and analog front end
  input  wire logic [1:0]       i_addr_sel,
  input  wire logic             i_remote_open,
  input  wire tmas_pkg::tmas_adc_t i_adc,
  // converter control
  output logic                  o_conv_start,
  output logic                  o_conv_busy
);

  tmas_pkg::tmas_link_t link_reg;
  tmas_pkg::tmas_link_t link_next;
  tmas_pkg::tmas_core_t core_reg;
  tmas_pkg::tmas_core_t core_next;

  // ---------------- link clock domain: pin sampling and event detection
  always_comb begin
    link_next          = link_reg;
    link_next.rst_sync = {link_reg.rst_sync[0], i_reset};
    link_next.scl      = {link_reg.scl[1:0], i_scl};
    link_next.sda      = {link_reg.sda[1:0], i_sda};
    if (link_reg.scl[1] && link_reg.scl[2] && link_reg.sda[2] && !link_reg.sda[1]) begin
      link_next.kind = tmas_pkg::TMAS_EV_START;
      link_next.tog  = ~link_reg.tog;
    end else if (link_reg.scl[1] && link_reg.scl[2] && !link_reg.sda[2] && link_reg.sda[1]) begin
      link_next.kind = tmas_pkg::TMAS_EV_STOP;
      link_next.tog  = ~link_reg.tog;
    end else if (link_reg.scl[1] && !link_reg.scl[2]) begin
      link_next.kind = tmas_pkg::TMAS_EV_RISE;
      link_next.tog  = ~link_reg.tog;
    end else if (!link_reg.scl[1] && link_reg.scl[2]) begin
      link_next.kind = tmas_pkg::TMAS_EV_FALL;
      link_next.tog  = ~link_reg.tog;
    end
    link_next.ev_sda = link_reg.sda[1];
    if (link_reg.rst_sync[1]) begin
      link_next.scl    = 3'h7;
      link_next.sda    = 3'h7;
      link_next.tog    = 1'b0;
      link_next.kind   = tmas_pkg::TMAS_EV_STOP;
      link_next.ev_sda = 1'b1;
    end
  end

  always_ff @(posedge i_link_clk) begin
    link_reg <= link_next;
  end

  // ---------------- core clock domain
  function automatic logic [7:0] read_mux(input tmas_pkg::tmas_core_t s);
    logic [7:0] d;
    d = `TMAS_RD_UNMAPPED;
    case (s.ptr)
      `TMAS_REG_LOC_VAL: d = s.loc_val;
      `TMAS_REG_REM_VAL: d = s.rem_val;
      `TMAS_REG_STATUS:  d = {1'b0, s.flags, 2'h0};
      `TMAS_REG_CFG_RD:  d = s.cfg;
      `TMAS_REG_LHI_RD:  d = s.lim[`TMAS_LIM_LHI];
      `TMAS_REG_LLO_RD:  d = s.lim[`TMAS_LIM_LLO];
      `TMAS_REG_RHI_RD:  d = s.lim[`TMAS_LIM_RHI];
      `TMAS_REG_RLO_RD:  d = s.lim[`TMAS_LIM_RLO];
      default:           d = `TMAS_RD_UNMAPPED;
    endcase
    return d;
  endfunction

  logic       evt;
  logic       ev_sda;
  logic       standby;
  logic       start_req;
  logic       ara_done;
  logic       addr_hit;
  logic [7:0] tx;
  logic [7:0] rem_new;
  logic [4:0] cmp;

  always_comb begin
    core_next            = core_reg;
    core_next.conv_start = 1'b0;
    // toggle edge marks a new pin event; its kind was stable long before the edge
    evt                  = core_reg.tog_sync[2] ^ core_reg.tog_sync[1];
    ev_sda               = link_reg.ev_sda;
    core_next.tog_sync   = {core_reg.tog_sync[1:0], link_reg.tog};
    core_next.open_sync  = {core_reg.open_sync[0], i_remote_open};
    core_next.strap_sync = {core_reg.strap_sync[0], i_addr_sel};
    standby              = core_reg.cfg[`TMAS_CFG_STBY_BIT];
    start_req            = 1'b0;
    ara_done             = 1'b0;
    addr_hit             = 1'b0;
    tx                   = 8'h00;
    rem_new              = i_adc.remote_low ? `TMAS_UNDER_RANGE : i_adc.remote_temp; // [RULE_16]
    cmp                  = 5'h00;

    // strap is caught once, after the synchroniser has filled
    if (core_reg.strap_cnt != 2'h3) begin
      core_next.strap_cnt = core_reg.strap_cnt + 2'h1;
    end
    if (core_reg.strap_cnt == `TMAS_STRAP_WAIT) begin
      core_next.dev_addr = `TMAS_DEV_ADDR_BASE + {5'h00, core_reg.strap_sync[1]};
    end

    // serial slave; runs regardless of standby [RULE_12]
    if (evt && link_reg.kind == tmas_pkg::TMAS_EV_START) begin
      core_next.smb     = tmas_pkg::TMAS_SMB_ADDR;
      core_next.bit_cnt = 4'h0;
      core_next.sda_oe  = 1'b0;
    end else if (evt && link_reg.kind == tmas_pkg::TMAS_EV_STOP) begin
      core_next.smb    = tmas_pkg::TMAS_SMB_IDLE;
      core_next.sda_oe = 1'b0;
    end else if (evt) begin
      case (core_reg.smb)
        tmas_pkg::TMAS_SMB_ADDR, tmas_pkg::TMAS_SMB_WDATA: begin
          if (link_reg.kind == tmas_pkg::TMAS_EV_RISE && core_reg.bit_cnt != 4'h8) begin
            core_next.shreg   = {core_reg.shreg[6:0], ev_sda};
            core_next.bit_cnt = core_reg.bit_cnt + 4'h1;
          end else if (link_reg.kind == tmas_pkg::TMAS_EV_FALL && core_reg.bit_cnt == 4'h8) begin
            if (core_reg.smb == tmas_pkg::TMAS_SMB_ADDR) begin
              addr_hit = (core_reg.shreg[7:1] == core_reg.dev_addr) ||
                         (core_reg.shreg[7:1] == `TMAS_ARA && core_reg.shreg[0] && core_reg.alert); // [RULE_06]
              core_next.rw    = core_reg.shreg[0];
              core_next.ara   = (core_reg.shreg[7:1] == `TMAS_ARA);
              core_next.first = 1'b1;
              core_next.smb   = addr_hit ? tmas_pkg::TMAS_SMB_ACK : tmas_pkg::TMAS_SMB_IDLE;
              core_next.sda_oe = addr_hit;
            end else begin
              core_next.smb    = tmas_pkg::TMAS_SMB_ACK;
              core_next.sda_oe = 1'b1;
              core_next.first  = 1'b0;
              if (core_reg.first) begin
                core_next.ptr = core_reg.shreg;
              end else begin
                case (core_reg.ptr)
                  `TMAS_REG_CFG_WR: core_next.cfg = core_reg.shreg; // [RULE_10]
                  `TMAS_REG_LHI_WR: core_next.lim[`TMAS_LIM_LHI] = core_reg.shreg;
                  `TMAS_REG_LLO_WR: core_next.lim[`TMAS_LIM_LLO] = core_reg.shreg;
                  `TMAS_REG_RHI_WR: core_next.lim[`TMAS_LIM_RHI] = core_reg.shreg;
                  `TMAS_REG_RLO_WR: core_next.lim[`TMAS_LIM_RLO] = core_reg.shreg;
                  // data byte is dropped; only the write itself matters
                  `TMAS_REG_ONE_SHOT: start_req = standby; // [RULE_13] [RULE_14]
                  default: ;
                endcase
              end
            end
          end
        end
        tmas_pkg::TMAS_SMB_ACK: begin
          if (link_reg.kind == tmas_pkg::TMAS_EV_FALL) begin
            core_next.bit_cnt = 4'h0;
            if (core_reg.rw) begin
              tx               = core_reg.ara ? {core_reg.dev_addr, 1'b0} : read_mux(core_reg); // [RULE_06]
              core_next.txbyte = tx;
              core_next.sda_oe = ~tx[7];
              core_next.smb    = tmas_pkg::TMAS_SMB_RDATA;
            end else begin
              core_next.sda_oe = 1'b0;
              core_next.smb    = tmas_pkg::TMAS_SMB_WDATA;
            end
          end
        end
        tmas_pkg::TMAS_SMB_RDATA: begin
          if (link_reg.kind == tmas_pkg::TMAS_EV_RISE) begin
            // released a one but another responder holds zero: withdraw
            if (!core_reg.sda_oe && !ev_sda) begin // [RULE_07]
              core_next.smb    = tmas_pkg::TMAS_SMB_IDLE;
              core_next.sda_oe = 1'b0;
            end else begin
              core_next.bit_cnt = core_reg.bit_cnt + 4'h1;
            end
          end else if (link_reg.kind == tmas_pkg::TMAS_EV_FALL) begin
            if (core_reg.bit_cnt == 4'h8) begin
              core_next.sda_oe = 1'b0;
              core_next.smb    = tmas_pkg::TMAS_SMB_RACK;
            end else begin
              core_next.txbyte = {core_reg.txbyte[6:0], 1'b0};
              core_next.sda_oe = ~core_reg.txbyte[6];
            end
          end
        end
        tmas_pkg::TMAS_SMB_RACK: begin
          if (link_reg.kind == tmas_pkg::TMAS_EV_RISE) begin
            core_next.more = ~ev_sda;
            ara_done       = core_reg.ara; // [RULE_08]
            core_next.ara  = 1'b0;
          end else if (link_reg.kind == tmas_pkg::TMAS_EV_FALL) begin
            core_next.bit_cnt = 4'h0;
            if (core_reg.more) begin
              tx               = read_mux(core_reg);
              core_next.txbyte = tx;
              core_next.sda_oe = ~tx[7];
              core_next.smb    = tmas_pkg::TMAS_SMB_RDATA;
            end else begin
              core_next.smb = tmas_pkg::TMAS_SMB_IDLE;
            end
          end
        end
        default: core_next.smb = tmas_pkg::TMAS_SMB_IDLE;
      endcase
    end

    // a won response releases only flags whose cause is gone [RULE_08] [RULE_20]
    if (ara_done) begin
      core_next.flags = core_reg.cond;
    end

    // periodic timebase; held at its reload value in standby
    if (standby || core_reg.period_cnt == 20'h00000) begin
      core_next.period_cnt = 20'(PERIOD_CYCLES - 1);
    end else begin
      core_next.period_cnt = core_reg.period_cnt - 20'h00001;
    end
    if (!standby && core_reg.period_cnt == 20'h00000) begin
      start_req = 1'b1; // [RULE_10]
    end

    case (core_reg.conv)
      tmas_pkg::TMAS_CV_IDLE: begin
        if (start_req) begin
          core_next.conv       = tmas_pkg::TMAS_CV_RUN;
          core_next.oneshot    = standby;
          core_next.cnt        = 20'(CONV_CYCLES - 1);
          core_next.conv_start = 1'b1;
          core_next.cond[`TMAS_FL_OPEN] = core_reg.open_sync[1]; // [RULE_15]
          if (core_reg.open_sync[1]) begin
            core_next.flags[`TMAS_FL_OPEN] = 1'b1; // [RULE_02]
          end
        end
      end
      tmas_pkg::TMAS_CV_RUN: begin
        if (standby && !core_reg.oneshot) begin
          core_next.conv = tmas_pkg::TMAS_CV_IDLE; // [RULE_11]
        end else if (core_reg.cnt == 20'h00000) begin
          // one-shot ends here too; standby bit was never touched [RULE_14]
          core_next.conv    = tmas_pkg::TMAS_CV_IDLE;
          core_next.oneshot = 1'b0;
          core_next.loc_val = i_adc.local_temp;
          core_next.rem_val = rem_new;
          cmp[`TMAS_FL_LHI] = $signed(i_adc.local_temp) > $signed(core_reg.lim[`TMAS_LIM_LHI]); // [RULE_19]
          cmp[`TMAS_FL_LLO] = $signed(i_adc.local_temp) < $signed(core_reg.lim[`TMAS_LIM_LLO]); // [RULE_19]
          cmp[`TMAS_FL_RHI] = $signed(rem_new) > $signed(core_reg.lim[`TMAS_LIM_RHI]);
          cmp[`TMAS_FL_RLO] = $signed(rem_new) < $signed(core_reg.lim[`TMAS_LIM_RLO]); // [RULE_17]
          cmp[`TMAS_FL_OPEN] = core_reg.cond[`TMAS_FL_OPEN];
          core_next.cond  = cmp;
          // set wins over a release in the same cycle
          core_next.flags = core_next.flags | cmp; // [RULE_01]
        end else begin
          core_next.cnt = core_reg.cnt - 20'h00001;
        end
      end
      default: core_next.conv = tmas_pkg::TMAS_CV_IDLE;
    endcase

    core_next.alert = |core_next.flags; // [RULE_20]

    if (i_reset) begin
      core_next            = '0;
      core_next.smb        = tmas_pkg::TMAS_SMB_IDLE;
      core_next.conv       = tmas_pkg::TMAS_CV_IDLE;
      core_next.dev_addr   = `TMAS_DEV_ADDR_BASE;
      core_next.cfg        = `TMAS_CFG_RST;
      core_next.lim[`TMAS_LIM_LHI] = `TMAS_LIM_HI_RST;
      core_next.lim[`TMAS_LIM_LLO] = `TMAS_LIM_LO_RST;
      core_next.lim[`TMAS_LIM_RHI] = `TMAS_LIM_HI_RST;
      core_next.lim[`TMAS_LIM_RLO] = `TMAS_LIM_LO_RST;
      core_next.period_cnt = 20'(PERIOD_CYCLES - 1);
    end
  end

  always_ff @(posedge i_clk) begin
    core_reg <= core_next;
  end

  // open-drain pins: value is always low, only the enable moves [RULE_03]
  assign o_sda_out     = 1'b0;
  assign o_sda_oe      = core_reg.sda_oe;
  assign o_alert_n_out = 1'b0;
  assign o_alert_n_oe  = core_reg.alert; // [RULE_01]
  assign o_conv_start  = core_reg.conv_start;
  assign o_conv_busy   = (core_reg.conv == tmas_pkg::TMAS_CV_RUN);

endmodule // tmas_top

// *** testbench/tmas_properties.sv ***
// port-level concurrent checks for the alert, standby and fault block
`timescale 1ns/1ps
module tmas_properties #(
  parameter int unsigned CONV_CYCLES = 25000
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // watched inputs
  input wire logic i_scl,
  input wire logic i_remote_open,
  // watched outputs
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_alert_n_out,
  input wire logic o_alert_n_oe,
  input wire logic o_conv_start,
  input wire logic o_conv_busy
);
  logic [15:0] busy_cnt, since_conv, scl_age, high_cnt, open_cnt;
  logic        scl_q;

  // saturating so long idle stretches never wrap into a false pass
  function automatic logic [15:0] inc(input logic [15:0] v);
    return v + {15'h0, ~&v};
  endfunction

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      busy_cnt <= 16'h0;
      since_conv <= 16'hFFFF;
      scl_age <= 16'hFFFF;
      high_cnt <= 16'h0;
      open_cnt <= 16'h0;
      scl_q <= 1'b1;
    end else begin
      busy_cnt <= o_conv_busy ? inc(busy_cnt) : 16'h0;
      since_conv <= (o_conv_busy | o_conv_start) ? 16'h0 : inc(since_conv);
      scl_age <= (i_scl & ~scl_q) ? 16'h0 : inc(scl_age);
      high_cnt <= i_scl ? inc(high_cnt) : 16'h0;
      open_cnt <= i_remote_open ? inc(open_cnt) : 16'h0;
      scl_q <= i_scl;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  property p_open_drain; o_alert_n_out == 1'b0 && o_sda_out == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin drives a high level");
  // an open sensor raises the flag at the start pulse itself, in the same cycle busy rises
  property p_alert_rise; $rose(o_alert_n_oe) |-> o_conv_start || since_conv < 16'h6; endproperty
  a_alert_rise: assert property (p_alert_rise) else $error("alert rose away from a conversion");
  property p_alert_fall; $fell(o_alert_n_oe) |-> scl_age < 16'h64; endproperty
  a_alert_fall: assert property (p_alert_fall) else $error("alert released without bus traffic");
  property p_busy_len; busy_cnt <= CONV_CYCLES + 2; endproperty
  a_busy_len: assert property (p_busy_len) else $error("conversion ran too long");
  property p_start_pulse; o_conv_start |=> !o_conv_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
  property p_start_idle; o_conv_start |-> !$past(o_conv_busy) ##[0:1] o_conv_busy; endproperty
  a_start_idle: assert property (p_start_idle) else $error("start overlaps or lacks busy");
  property p_open_alert; o_conv_start && open_cnt > 16'h6 |-> ##[0:3] o_alert_n_oe; endproperty
  a_open_alert: assert property (p_open_alert) else $error("open sensor did not alert");
  property p_sda_idle; high_cnt > 16'h64 |-> !o_sda_oe; endproperty
  a_sda_idle: assert property (p_sda_idle) else $error("data pulled low on idle bus");
  property p_sda_change; $changed(o_sda_oe) |-> !i_scl; endproperty
  a_sda_change: assert property (p_sda_change) else $error("data changed while clock high");

  c_alert: cover property ($rose(o_alert_n_oe));
  c_ack: cover property ($rose(o_sda_oe));
  c_start: cover property (o_conv_start);
endmodule // tmas_properties

// *** testbench/tmas_smb_host.sv ***
// bus master model of the serial management link
`timescale 1ns/1ps
module tmas_smb_host #(
  parameter int HALF = 200
) (
  // device pull on the data line
  input  wire logic i_dev_oe,
  // wire levels
  output logic      o_scl,
  output logic      o_sda
);
  localparam logic [6:0] DEV = 7'h4C;  // differs from the response address
  localparam logic [6:0] ARA = 7'h0C;
  logic drv;

  // pull-up: a released line reads high
  assign o_sda = drv & ~i_dev_oe;
  initial begin
    drv = 1'b1;
    o_scl = 1'b1;
  end

  task automatic clk_bit(input logic b, output logic r);
    #(HALF/4) drv = b;
    #(HALF*3/4) o_scl = 1'b1;
    #(HALF/2) r = o_sda;
    #(HALF/2) o_scl = 1'b0;
  endtask

  // ack comes back true when the slave pulled the ninth bit low
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) clk_bit(tx[i], rx[i]);
    clk_bit(1'b1, ack);
    ack = ~ack;
  endtask

  task automatic start();
    drv = 1'b1;
    o_scl = 1'b1;
    #HALF drv = 1'b0;
    #HALF o_scl = 1'b0;
  endtask

  task automatic stop();
    #(HALF/4) drv = 1'b0;
    #(HALF*3/4) o_scl = 1'b1;
    #HALF drv = 1'b1;
    #HALF;
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d, input logic has_d, output logic ok);
    logic [7:0] rx;
    logic a1, a2, a3;
    start();
    xfer({DEV, 1'b0}, rx, a1);
    xfer(ptr, rx, a2);
    a3 = 1'b1;
    if (has_d) xfer(d, rx, a3);
    stop();
    ok = a1 & a2 & a3;
  endtask

  // tx other than FF imitates a rival responder on the wired line
  task automatic rd(input logic [6:0] addr, input logic [7:0] tx, output logic [7:0] d, output logic ok);
    logic a;
    start();
    xfer({addr, 1'b1}, d, ok);
    xfer(tx, d, a);
    stop();
  endtask

  task automatic ara(input logic [7:0] tx, output logic [7:0] d);
    logic ok;
    rd(ARA, tx, d, ok);
  endtask
endmodule // tmas_smb_host

// *** testbench/temp_monitor_alert_standby_tb.sv ***
// self-checking bench for the alert, standby and fault block
`timescale 1ns/1ps
bind tmas_top tmas_properties #(.CONV_CYCLES(CONV_CYCLES)) chk_u (
  .i_clk(i_clk), .i_reset(i_reset), .i_scl(i_scl), .i_remote_open(i_remote_open),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_alert_n_out(o_alert_n_out),
  .o_alert_n_oe(o_alert_n_oe), .o_conv_start(o_conv_start), .o_conv_busy(o_conv_busy));

module temp_monitor_alert_standby_tb;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic ropen = 1'b0;
  logic scl, sda, sda_out, sda_oe, al_out, al_oe, cst, busy;
  tmas_pkg::tmas_adc_t adc = '0;
  int miscompares = 0;
  int tests_run = 0;
  int starts = 0;

  always #2 clk = ~clk;
  initial #7 forever #15 link_clk = ~link_clk;
  always @(posedge clk) if (cst === 1'b1) starts++;

  tmas_top #(.CONV_CYCLES(20), .PERIOD_CYCLES(100)) dut_u (
    .i_clk(clk), .i_reset(rst), .i_link_clk(link_clk), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_alert_n_out(al_out), .o_alert_n_oe(al_oe),
    .i_addr_sel(2'h0), .i_remote_open(ropen), .i_adc(adc), .o_conv_start(cst), .o_conv_busy(busy));
  tmas_smb_host host_u (.i_dev_oe(sda_oe), .o_scl(scl), .o_sda(sda));

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic alert_is(input logic e);
    check({7'h0, al_oe}, {7'h0, e});
  endtask

  task automatic put(input logic [7:0] l, input logic [7:0] r, input logic o);
    @(posedge clk);
    #1 adc.local_temp = l;
    adc.remote_temp = r;
    adc.remote_low = 1'b0;
    ropen = o;
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic ok;
    host_u.wr(ptr, d, 1'b1, ok);
    check({7'h0, ok}, 8'h01);
  endtask

  task automatic rchk(input logic [7:0] ptr, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host_u.wr(ptr, 8'h00, 1'b0, ok);
    host_u.rd(7'h4C, 8'hFF, d, ok);
    check(d, exp);
  endtask

  // waits for a fresh conversion to start and finish, bounded
  task automatic conv();
    int n;
    n = 0;
    while (cst !== 1'b1 && n < 1000) begin @(posedge clk); #1 n++; end
    @(posedge clk);
    #1;
    while (busy !== 1'b0 && n < 1000) begin @(posedge clk); #1 n++; end
    if (n >= 1000) begin miscompares++; finish_test(); end
    repeat (4) @(posedge clk);
  endtask

  task automatic t_reset();
    rchk(8'h03, 8'h00);
    rchk(8'h06, 8'hC9);
    rchk(8'h04, 8'h00);
    alert_is(1'b0);
  endtask

  task automatic t_limit();
    logic [7:0] d;
    wr(8'h0B, 8'h32);
    put(8'h32, 8'h00, 1'b0);
    conv();
    alert_is(1'b0);
    put(8'hC9, 8'h00, 1'b0);
    conv();
    alert_is(1'b0);
    put(8'h33, 8'h00, 1'b0);
    conv();
    alert_is(1'b1);
    host_u.ara(8'h00, d);
    alert_is(1'b1);
    host_u.ara(8'hFF, d);
    check(d, {7'h4C, 1'b0});
    alert_is(1'b1);
    put(8'h32, 8'h00, 1'b0);
    conv();
    alert_is(1'b1);
    host_u.ara(8'hFF, d);
    alert_is(1'b0);
  endtask

  task automatic t_short();
    logic [7:0] d;
    // under-range flag must replace whatever code the converter offers
    put(8'h32, 8'h20, 1'b0);
    adc.remote_low = 1'b1;
    conv();
    rchk(8'h01, 8'h80);
    alert_is(1'b1);
    rchk(8'h02, 8'h08);
    wr(8'h0E, 8'h80);
    conv();
    host_u.ara(8'hFF, d);
    alert_is(1'b0);
  endtask

  task automatic t_standby();
    int n;
    wr(8'h09, 8'h40);
    check({7'h0, busy}, 8'h00);
    n = starts;
    put(8'h10, 8'h20, 1'b0);
    repeat (300) @(posedge clk);
    check(8'(starts - n), 8'h00);
    rchk(8'h00, 8'h32);
    wr(8'h0F, 8'hA5);
    rchk(8'h00, 8'h10);
    rchk(8'h03, 8'h40);
    check(8'(starts - n), 8'h01);
  endtask

  task automatic t_open();
    logic [7:0] d;
    put(8'h10, 8'h20, 1'b1);
    wr(8'h0F, 8'h00);
    rchk(8'h02, 8'h04);
    alert_is(1'b1);
    put(8'h10, 8'h20, 1'b0);
    wr(8'h0F, 8'h00);
    host_u.ara(8'hFF, d);
    alert_is(1'b0);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    repeat (100) @(posedge clk);
    t_reset();
    t_limit();
    t_short();
    t_standby();
    t_open();
    finish_test();
  end

  initial begin
    #390000;
    miscompares++;
    finish_test();
  end
endmodule // temp_monitor_alert_standby_tb
